// File: verilog/afc_consts.svh
// Purpose: Constants for the receive FIFO flow controller
// Assumes: 25 MHz clock, AHB-Lite register access
// Notes:   Operation of the block summarised below
//
// Operation
// RULE1: Any-frame mode: FIFO at high level triggers back pressure or pause.
// RULE2: In full duplex, the any-frame bit alone enables automatic pause.
// RULE3: Half duplex any-frame: jam at preamble, no address decode.
// RULE4: Full duplex any-frame: request pause as soon as high level reached.
// RULE5: Pause request is held until the MAC takes it.
// RULE6: Any-frame bit overrides multicast, broadcast and own-address bits.
// RULE7: Jam code: 5,10,15,25,50us then 50us steps; 10M adds 2.2us.
// RULE8: High level in 64-byte units; pause time from MAC flow value.
// RULE9: Zero-time pause below low level, only after high pause sent.
// RULE10: Jam code in bits 7:4, used only in half duplex.
// RULE11: No pause and no back pressure while transmitter disabled.
// RULE12: Jam ends after duration; each later qualifying frame retriggers.
`ifndef AFC_CONSTS_SVH
`define AFC_CONSTS_SVH
`define AUTO_FLOW_CONTROL_CONFIG_ADDR          8'hac
`define AFC_STAT_ADDR         8'hc0
`define AFC_ADDR_MSB          7
`define AUTO_FLOW_CONTROL_CONFIG_RST           32'h0000_0000
`define AUTO_FLOW_CONTROL_CONFIG_WMASK         32'h00ff_ffff
`define AFC_LVL_SHIFT         6
`define AFC_HTRANS_BUSY_BIT   1
`define AFC_HRESP_OKAY        1'b0
`define AFC_PAUSE_ZERO        16'h0000
`define AFC_CLK_PERIOD_NS     40
`define AFC_TICK_NS           200
`define AFC_JAM_T0_NS         5000
`define AFC_JAM_T1_NS         10000
`define AFC_JAM_T2_NS         15000
`define AFC_JAM_T3_NS         25000
`define AFC_JAM_STEP_NS       50000
`define AFC_JAM_STEP_BASE     3
`define AFC_JAM_10M_EXTRA_NS  2200
`endif

// File: verilog/afc_pkg.sv
// Purpose: Types for the receive FIFO flow controller
// Assumes: Field layout of the configuration word
// Notes:   Carriers travel as packed structs
package afc_pkg;
  typedef struct packed {
    logic [7:0] rsvd;
    logic [7:0] fifo_high_threshold;
    logic [7:0] fifo_low_threshold;
    logic [3:0] jam_duration_select;
    logic       multicast_flow_enable;
    logic       broadcast_flow_enable;
    logic       own_address_flow_enable;
    logic       any_frame_flow_enable;
  } auto_flow_control_config_t;
  typedef struct packed {
    logic [26:0] rsvd;
    logic        below_low;
    logic        at_high;
    logic        paused;
    logic        pause_pending;
    logic        jam_active;
  } afc_status_t;
  typedef struct packed {
    logic preamble;
    logic addr_done;
    logic is_multicast;
    logic is_broadcast;
    logic is_own_addr;
  } afc_rx_t;
  typedef struct packed {
    logic        req;
    logic        zero_time;
    logic [15:0] pause_time_value;
  } afc_pause_t;
  typedef enum logic [1:0] {PS_IDLE, PS_HI_REQ, PS_SENT, PS_LO_REQ}
    afc_pstate_t;
endpackage : afc_pkg

// File: verilog/afc_jam_timer.sv
// Purpose: Back-pressure duration timer
// Assumes: Start and abort are single-cycle qualified
// Notes:   Counts in 200 ns ticks
`timescale 1ns/1ps
`include "afc_consts.svh"
module afc_jam_timer #(
  parameter int unsigned P_TICK_CYC = `AFC_TICK_NS / `AFC_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // Control
  input  wire logic       i_start,
  input  wire logic       i_abort,
  input  wire logic [3:0] i_code,
  input  wire logic       i_speed_100,
  // Status
  output logic            o_busy
);
  if (P_TICK_CYC < 1 || P_TICK_CYC > 255) begin : g_bad_tick
    $error("P_TICK_CYC out of range");
  end

  function automatic logic [15:0] jam_units(logic [3:0] c, logic s100);
    logic [31:0] ns;
    case (c)
      4'h0: ns = `AFC_JAM_T0_NS;
      4'h1: ns = `AFC_JAM_T1_NS;
      4'h2: ns = `AFC_JAM_T2_NS;
      4'h3: ns = `AFC_JAM_T3_NS;
      default: ns = (32'(c) - 32'(`AFC_JAM_STEP_BASE)) * `AFC_JAM_STEP_NS;
    endcase
    if (!s100) begin
      ns = ns + `AFC_JAM_10M_EXTRA_NS;
    end
    return 16'(ns / `AFC_TICK_NS);
  endfunction : jam_units

  localparam logic [7:0] TICK_LAST = 8'(P_TICK_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  logic [15:0] units_left;
  logic [7:0]  pre;
  logic [15:0] next_units_left;
  logic [7:0]  next_pre;
  logic        next_busy;

  always_comb begin
    next_units_left = units_left;
    next_pre        = pre;
    next_busy       = o_busy;
    if (i_abort) begin
      next_busy = 1'b0;
    end else if (i_start) begin
      next_units_left = jam_units(i_code, i_speed_100); // RULE7
      next_pre        = TICK_LAST;
      next_busy       = 1'b1;
    end else if (o_busy) begin
      if (pre == 8'h00) begin
        next_pre = TICK_LAST;
        if (units_left == 16'h0001) begin
          next_busy = 1'b0; // RULE12
        end else begin
          next_units_left = units_left - 16'h0001;
        end
      end else begin
        next_pre = pre - 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      units_left <= 16'h0000;
      pre        <= 8'h00;
      o_busy     <= 1'b0;
    end else if (i_ce) begin
      units_left <= next_units_left;
      pre        <= next_pre;
      o_busy     <= next_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Helper: busy cycles since last start
  logic [31:0] run_cyc;
  logic [31:0] units_l;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_cyc <= 32'h0000_0000;
      units_l <= 32'h0000_0000;
    end else if (i_ce) begin
      if (i_start) begin
        run_cyc <= 32'h0000_0000;
        units_l <= 32'(jam_units(i_code, i_speed_100));
      end else if (o_busy) begin
        run_cyc <= run_cyc + 32'h0000_0001;
      end
    end
  end

  property p_jam_len;
    @(posedge i_clk) disable iff (i_rst || !i_ce)
    $fell(o_busy) && !$past(i_abort) && !$past(i_start)
      |-> run_cyc == units_l * P_TICK_CYC;
  endproperty
  a_jam_len: assert property (p_jam_len) // RULE7 RULE12
    else $error("jam length wrong");
endmodule : afc_jam_timer

// File: verilog/afc_flow_ctrl.sv
// Purpose: Automatic receive flow control (pause and back pressure)
// Assumes: MAC supplies duplex, speed, tx enable and frame events
// Notes:   Zero-wait AHB-Lite slave, one clock domain
`timescale 1ns/1ps
`include "afc_consts.svh"
module afc_flow_ctrl #(
  parameter int unsigned P_LVL_W    = 14,
  parameter int unsigned P_TICK_CYC = `AFC_TICK_NS / `AFC_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_ce,
  // AHB-Lite slave
  input  wire logic                i_hsel,
  input  wire logic [31:0]         i_haddr,
  input  wire logic [1:0]          i_htrans,
  input  wire logic                i_hwrite,
  input  wire logic [2:0]          i_hsize,
  input  wire logic [31:0]         i_hwdata,
  input  wire logic                i_hready,
  output logic      [31:0]         o_hrdata,
  output logic                     o_hreadyout,
  output logic                     o_hresp,
  // MAC state
  input  wire logic                i_full_duplex,
  input  wire logic                i_speed_100,
  input  wire logic                i_tx_enable,
  input  wire logic [15:0]         i_pause_time_value,
  // Receive side
  input  wire logic [P_LVL_W-1:0]  i_rx_fifo_bytes,
  input  wire afc_pkg::afc_rx_t    i_rx,
  // Flow outputs and pause acknowledge input
  output logic                     o_jam,
  output afc_pkg::afc_pause_t      o_pause,
  input  wire logic                i_pause_ack
);
  if (P_LVL_W < 14 || P_LVL_W > 30) begin : g_bad_lvl
    $error("P_LVL_W out of range");
  end

  function automatic logic [P_LVL_W-1:0] to_bytes(logic [7:0] units);
    return P_LVL_W'(units) << `AFC_LVL_SHIFT;
  endfunction : to_bytes

  ////////////////////////////////////////////////////////////////////////
  // Register bus
  afc_pkg::auto_flow_control_config_t    cfg;
  afc_pkg::auto_flow_control_config_t    next_cfg;
  afc_pkg::afc_status_t stat;
  logic                 wr_act;
  logic [7:0]           wr_addr;
  logic                 next_wr_act;
  logic [7:0]           next_wr_addr;
  logic [31:0]          next_hrdata;
  logic                 addr_ok;

  assign o_hreadyout = 1'b1;
  assign o_hresp     = `AFC_HRESP_OKAY;
  assign addr_ok     = i_hsel && i_hready && i_htrans[`AFC_HTRANS_BUSY_BIT];

  always_comb begin
    next_cfg     = cfg;
    next_wr_act  = addr_ok && i_hwrite;
    next_wr_addr = i_haddr[`AFC_ADDR_MSB:0];
    next_hrdata  = o_hrdata;
    if (wr_act && wr_addr == `AUTO_FLOW_CONTROL_CONFIG_ADDR) begin
      next_cfg = afc_pkg::auto_flow_control_config_t'(i_hwdata & `AUTO_FLOW_CONTROL_CONFIG_WMASK);
    end
    if (addr_ok && !i_hwrite) begin
      case (i_haddr[`AFC_ADDR_MSB:0])
        `AUTO_FLOW_CONTROL_CONFIG_ADDR:  next_hrdata = 32'(next_cfg);
        `AFC_STAT_ADDR: next_hrdata = 32'(stat);
        default:        next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg      <= afc_pkg::auto_flow_control_config_t'(`AUTO_FLOW_CONTROL_CONFIG_RST);
      wr_act   <= 1'b0;
      wr_addr  <= 8'h00;
      o_hrdata <= 32'h0000_0000;
    end else if (i_ce) begin
      cfg      <= next_cfg;
      wr_act   <= next_wr_act;
      wr_addr  <= next_wr_addr;
      o_hrdata <= next_hrdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Level compare
  logic at_hi;
  logic below_lo;
  logic fd_en;
  logic hd_en;
  logic qual;
  logic trig;

  assign at_hi    = i_rx_fifo_bytes >= to_bytes(cfg.fifo_high_threshold); // RULE8
  assign below_lo = i_rx_fifo_bytes < to_bytes(cfg.fifo_low_threshold); // RULE9
  assign fd_en    = i_full_duplex && cfg.any_frame_flow_enable
                    && i_tx_enable; // RULE2 RULE11
  assign hd_en    = !i_full_duplex && i_tx_enable && at_hi; // RULE10 RULE11
  // Address qualifiers only count when any-frame is off
  assign qual = i_rx.addr_done && !cfg.any_frame_flow_enable
                && ((cfg.multicast_flow_enable && i_rx.is_multicast)
                 || (cfg.broadcast_flow_enable && i_rx.is_broadcast)
                 || (cfg.own_address_flow_enable && i_rx.is_own_addr)); // RULE6
  // Retrigger on every qualifying frame keeps the jam going under load
  assign trig = hd_en && ((cfg.any_frame_flow_enable && i_rx.preamble)
                          || qual); // RULE1 RULE3 RULE12

  afc_jam_timer #(
    .P_TICK_CYC (P_TICK_CYC)
  ) u_timer (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_ce        (i_ce),
    .i_start     (trig),
    .i_abort     (i_full_duplex || !i_tx_enable), // RULE10 RULE11
    .i_code      (cfg.jam_duration_select),
    .i_speed_100 (i_speed_100),
    .o_busy      (o_jam)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pause requests
  afc_pkg::afc_pstate_t pst;
  afc_pkg::afc_pstate_t next_pst;
  logic [15:0]          ptime;
  logic [15:0]          next_ptime;

  always_comb begin
    next_pst   = pst;
    next_ptime = ptime;
    case (pst)
      afc_pkg::PS_IDLE: begin
        if (fd_en && at_hi) begin
          next_pst   = afc_pkg::PS_HI_REQ; // RULE1 RULE4
          next_ptime = i_pause_time_value; // RULE8
        end
      end
      afc_pkg::PS_HI_REQ: begin
        if (!i_tx_enable) begin
          next_pst = afc_pkg::PS_IDLE; // RULE11
        end else if (i_pause_ack) begin
          next_pst = afc_pkg::PS_SENT; // RULE5
        end
      end
      afc_pkg::PS_SENT: begin
        if (!fd_en) begin
          next_pst = afc_pkg::PS_IDLE;
        end else if (below_lo) begin
          next_pst   = afc_pkg::PS_LO_REQ; // RULE9
          next_ptime = `AFC_PAUSE_ZERO;
        end
      end
      afc_pkg::PS_LO_REQ: begin
        if (!i_tx_enable || i_pause_ack) begin
          next_pst = afc_pkg::PS_IDLE; // RULE5 RULE11
        end
      end
      default: next_pst = afc_pkg::PS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pst   <= afc_pkg::PS_IDLE;
      ptime <= `AFC_PAUSE_ZERO;
    end else if (i_ce) begin
      pst   <= next_pst;
      ptime <= next_ptime;
    end
  end

  always_comb begin
    o_pause.req              = (pst == afc_pkg::PS_HI_REQ)
                               || (pst == afc_pkg::PS_LO_REQ);
    o_pause.zero_time        = pst == afc_pkg::PS_LO_REQ;
    o_pause.pause_time_value = ptime;
    stat                     = '0;
    stat.below_low           = below_lo;
    stat.at_high             = at_hi;
    stat.paused              = pst == afc_pkg::PS_SENT;
    stat.pause_pending       = o_pause.req;
    stat.jam_active          = o_jam;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst || !i_ce);

  property p_fd_pause;
    pst == afc_pkg::PS_IDLE && fd_en && at_hi
      |=> o_pause.req && !o_pause.zero_time
          && o_pause.pause_time_value == $past(i_pause_time_value);
  endproperty
  a_fd_pause: assert property (p_fd_pause) // RULE4
    else $error("no pause at high level");

  property p_any_off;
    !cfg.any_frame_flow_enable && pst == afc_pkg::PS_IDLE
      |=> !o_pause.req;
  endproperty
  a_any_off: assert property (p_any_off) // RULE2
    else $error("pause without any-frame");

  property p_preamble_jam;
    hd_en && cfg.any_frame_flow_enable && i_rx.preamble |=> o_jam;
  endproperty
  a_preamble_jam: assert property (p_preamble_jam) // RULE3
    else $error("no jam at preamble");

  property p_hold_req;
    o_pause.req && !i_pause_ack && i_tx_enable
      |=> o_pause.req && $stable(o_pause);
  endproperty
  a_hold_req: assert property (p_hold_req) // RULE5
    else $error("pause request dropped");

  property p_override;
    !o_jam && cfg.any_frame_flow_enable && i_rx.addr_done
      && !i_rx.preamble |=> !o_jam;
  endproperty
  a_override: assert property (p_override) // RULE6
    else $error("qualifier used in any-frame mode");

  property p_zero_pause;
    pst == afc_pkg::PS_SENT && fd_en && below_lo
      |=> o_pause.req && o_pause.zero_time
          && o_pause.pause_time_value == `AFC_PAUSE_ZERO;
  endproperty
  a_zero_pause: assert property (p_zero_pause) // RULE9
    else $error("zero pause missing");

  property p_zero_only_after;
    $rose(o_pause.zero_time) |-> $past(pst) == afc_pkg::PS_SENT;
  endproperty
  a_zero_only_after: assert property (p_zero_only_after) // RULE9
    else $error("zero pause without high pause");

  property p_fd_no_jam;
    i_full_duplex |=> !o_jam;
  endproperty
  a_fd_no_jam: assert property (p_fd_no_jam) // RULE10
    else $error("jam in full duplex");

  property p_tx_off;
    !i_tx_enable |=> !o_jam && !o_pause.req;
  endproperty
  a_tx_off: assert property (p_tx_off) // RULE11
    else $error("flow action with tx off");

  property p_hi_level;
    o_pause.req && !o_pause.zero_time |-> $past(at_hi, 1)
      || $past(pst) == afc_pkg::PS_HI_REQ;
  endproperty
  a_hi_level: assert property (p_hi_level) // RULE1 RULE8
    else $error("pause below high level");

  c_full_cycle: cover property (pst == afc_pkg::PS_LO_REQ && i_pause_ack);
  c_pre_jam: cover property (trig && cfg.any_frame_flow_enable ##1 o_jam);
  c_qual_jam: cover property (qual && hd_en ##1 o_jam);
  c_jam_end: cover property ($fell(o_jam) && !i_full_duplex);
endmodule : afc_flow_ctrl

// File: verif/afc_mac_model.sv
// Purpose: MAC transmitter stand-in taking pause requests
// Assumes: Request level held until ack pulse
// Notes:   Ack after a random wait of 0..3 cycles
`timescale 1ns/1ps
module afc_mac_model (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  // Pause link
  input  wire afc_pkg::afc_pause_t  i_pause,
  output logic                      o_ack
);
  int unsigned wait_cnt;
  int unsigned wait_len;
  // Queued until a free window; a slow window models a frame in flight
  always @(posedge i_clk) begin
    if (i_rst || (i_pause.req !== 1'b1) || o_ack) begin
      o_ack    <= 1'b0;
      wait_cnt <= 0;
      wait_len <= $urandom_range(3, 0);
    end else if (wait_cnt >= wait_len) begin
      o_ack <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : afc_mac_model

// File: verif/afc_flow_ctrl_tb.sv
// Purpose: Self-checking bench for the flow controller
// Assumes: One jam tick per clock to keep jams short
// Notes:   Expected results queued, a watcher compares them
`timescale 1ns/1ps
module afc_flow_ctrl_tb;
  logic                clk = 1'b0;
  logic                rst;
  logic                hsel;
  logic [31:0]         haddr;
  logic [1:0]          htrans;
  logic                hwrite;
  logic [31:0]         hwdata;
  logic [31:0]         hrdata;
  wire logic           hready;
  logic                hresp;
  logic                ce = 1'b1;
  logic                fd;
  logic                spd;
  logic                tx;
  logic [15:0]         ptv;
  logic [13:0]         bytes;
  afc_pkg::afc_rx_t    rx;
  logic                jam;
  afc_pkg::afc_pause_t pause;
  logic                ack;
  logic [31:0]         q_rd[$];
  logic [31:0]         q_jam[$];
  logic [31:0]         q_pz[$];
  logic [31:0]         r;
  logic                rd_pend = 1'b0;
  logic                req_q = 1'b0;
  int                  jam_len = 0;
  int                  cyc = 0;
  int                  n_mismatch = 0;
  int                  check_count = 0;

  always #20 clk = ~clk;

  afc_flow_ctrl #(.P_TICK_CYC(1)) dut (
    .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_full_duplex(fd), .i_speed_100(spd), .i_tx_enable(tx),
    .i_pause_time_value(ptv), .i_rx_fifo_bytes(bytes), .i_rx(rx),
    .o_jam(jam), .o_pause(pause), .i_pause_ack(ack)
  );

  afc_mac_model mac (
    .i_clk(clk), .i_rst(rst), .i_pause(pause), .o_ack(ack)
  );

  ////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task end_sim;
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Jam length in cycles at one tick per clock
  function automatic int jcyc(input int c, input logic s);
    int u;
    u = (c < 4) ? ((c == 3) ? 125 : 25 * (c + 1)) : 250 * (c - 3);
    return s ? u : u + 11;
  endfunction : jcyc

  function automatic logic [31:0] cfg_w(input logic [3:0] c,
                                        input logic [3:0] q);
    return {8'h00, 8'h10, 8'h08, c, q};
  endfunction : cfg_w

  ////////////////////////////////////////////////////////////////////
  // Empty queue yields unknown, so any stray result is a mismatch
  always @(posedge clk) begin
    if (rd_pend) begin
      chk("rdata", q_rd.size() ? q_rd.pop_front() : 'x, hrdata);
      chk("hresp", 32'h0, {31'h0, hresp});
    end
    rd_pend = hsel && htrans[1] && !hwrite;
    if (jam === 1'b1)
      jam_len++;
    else if (jam_len > 0) begin
      chk("jam", q_jam.size() ? q_jam.pop_front() : 'x, jam_len);
      jam_len = 0;
    end
    if (pause.req === 1'b1 && !req_q)
      chk("pause", q_pz.size() ? q_pz.pop_front() : 'x,
          {15'h0, pause.zero_time, pause.pause_time_value});
    req_q = (pause.req === 1'b1);
    cyc++;
    if (cyc > 60000) begin
      n_mismatch++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
  endtask : ahb

  task rd(input logic [7:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask : rd

  // Pulse a receive event; e below zero means no jam expected
  task rxp(input logic [4:0] v, input int e);
    int k;
    if (e >= 0)
      q_jam.push_back(e);
    @(posedge clk);
    rx <= v;
    @(posedge clk);
    rx <= '0;
    k = 0;
    repeat (2) @(posedge clk);
    while (jam !== 1'b0 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk);
  endtask : rxp

  task wait_pz;
    int k;
    k = 0;
    while (pause.req !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    while (pause.req !== 1'b0 && k < 100) begin
      @(posedge clk);
      k++;
    end
    repeat (2) @(posedge clk);
  endtask : wait_pz

  ////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h4a4e8d42));
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    fd = 1'b0;
    spd = 1'b1;
    tx = 1'b1;
    ptv = 16'h0;
    bytes = 14'h0;
    rx = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'hac, 32'h0);
    ahb(1'b1, 8'hac, 32'hffff_ffff);
    rd(8'hac, 32'h00ff_ffff);
    rd(8'h10, 32'h0);
    for (int s = 0; s < 2; s++) begin
      spd <= s[0];
      for (int c = 0; c < 16; c++) begin
        ahb(1'b1, 8'hac, cfg_w(c[3:0], 4'h1));
        bytes <= 14'd1024 + 14'($urandom_range(2000, 0));
        rxp(5'b10000, jcyc(c, s[0]));
      end
    end
    // Threshold edge: one byte short, then exactly at level
    ahb(1'b1, 8'hac, cfg_w(4'h0, 4'h1));
    bytes <= 14'd1023;
    rxp(5'b10000, -1);
    bytes <= 14'd1024;
    rxp(5'b10000, 25);
    // Clock enable low for 10 cycles stretches the jam by 10
    q_jam.push_back(35);
    @(posedge clk);
    rx <= 5'b10000;
    @(posedge clk);
    rx <= '0;
    repeat (5) @(posedge clk);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    rxp(5'b00000, -1);
    // Second preamble ten cycles in restarts the full jam
    q_jam.push_back(35);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      rx <= 5'b10000;
      @(posedge clk);
      rx <= '0;
      repeat (8) @(posedge clk);
    end
    rxp(5'b00000, -1);
    rd(8'hc0, 32'h0000_0008);
    for (int q = 0; q < 3; q++) begin
      ahb(1'b1, 8'hac, cfg_w(4'h0, 4'(2 << q)));
      rxp({2'b01, 3'(1 << q)}, 25);
      rxp({2'b01, 3'(7 ^ (1 << q))}, -1);
    end
    // Any-frame set: address qualifiers ignored, preamble alone jams
    ahb(1'b1, 8'hac, cfg_w(4'h0, 4'hf));
    rxp(5'b01111, -1);
    rxp(5'b10000, 25);
    fd <= 1'b1;
    ahb(1'b1, 8'hac, cfg_w(4'hf, 4'h0));
    bytes <= 14'd2000;
    repeat (30) @(posedge clk);
    r = $urandom();
    ptv <= r[15:0];
    q_pz.push_back({16'h0, r[15:0]});
    ahb(1'b1, 8'hac, cfg_w(4'hf, 4'h1));
    rxp(5'b10000, -1);
    wait_pz();
    rd(8'hc0, 32'h0000_000c);
    q_pz.push_back(32'h0001_0000);
    bytes <= 14'd511;
    wait_pz();
    bytes <= 14'd0;
    tx <= 1'b0;
    repeat (4) @(posedge clk);
    bytes <= 14'd2000;
    repeat (30) @(posedge clk);
    fd <= 1'b0;
    rxp(5'b10000, -1);
    chk("left", 32'h0, q_jam.size() + q_pz.size() + q_rd.size());
    end_sim();
  end
endmodule : afc_flow_ctrl_tb
